// [include/acr1_cfg.svh]
// constants of the second converter control register
`ifndef ACR1_CFG_SVH
`define ACR1_CFG_SVH
`define ACR1_RESET_VALUE   10'h030
`define ACR1_SEL_VALUE     2'h1
`define ACR1_BIT_RESET     0
`define ACR1_BIT_SYNC      1
`define ACR1_BIT_BUSSTYLE  6
`define ACR1_BIT_FORMAT    7
`define ACR1_BIT_OFFSET    8
`endif

// [include/acr1_pkg.sv]
// types of the second converter control register
package acr1_pkg;
  typedef struct packed {
    logic select_low_active_n;
    logic select_high_active;
    logic rd_n;
    logic wr_n;
  } acr1_bus_t;
  typedef enum logic [1:0] {
    ACR1_IDLE = 2'b00,
    ACR1_CAL  = 2'b01,
    ACR1_RUN  = 2'b10
  } acr1_state_t;
endpackage

// [rtl/acr1_ctrl.sv]
// second control register with bus decode, calibration and result formatting
`timescale 1ns/1ps
`include "acr1_cfg.svh"
module acr1_ctrl (
  input  wire logic              core_clk_in,       // 20 MHz core clock
  input  wire logic              nrst_in,           // async reset, active low
  input  wire acr1_pkg::acr1_bus_t bus_in,          // host strobes and selects
  input  wire logic [11:0]       data_in,           // host data word
  input  wire logic              conv_valid_in,     // raw conversion ready pulse
  input  wire logic [9:0]        conv_data_in,      // raw result, twos complement
  output logic                   cal_zero_in_out,   // force analog inputs to zero
  output logic                   device_reset_out,  // whole device held in reset
  output logic                   sync_gen_clear_out,// one-cycle sync generator clear
  output logic                   read_strobe_out,   // internal read strobe
  output logic                   result_valid_out,  // corrected result ready
  output logic [9:0]             result_out,        // corrected, formatted result
  output logic                   cr0_write_out,     // write aimed at register 0
  output logic [9:0]             ctrl_value_out     // current register contents
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [9:0]             ctrl_reg;
  logic [9:0]             ctrl_next;
  logic [9:0]             offset_reg;

  logic                   wr_int;
  logic                   wr_prev_reg;
  logic                   wr_take;
  logic                   rd_int;
  logic                   sel_ok;
  logic                   own_take;
  logic                   cal_start;
  logic                   cal_done;
  logic                   conv_shown;
  logic                   combined_style;
  logic                   straight_binary;

  acr1_pkg::acr1_state_t  state_reg;
  acr1_pkg::acr1_state_t  state_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // format select flips only the sign bit, twos complement to offset binary
  function automatic logic [9:0] fmt(input logic [9:0] v, input logic bin);
    if (bin)
      fmt = {~v[9], v[8:0]};
    else
      fmt = v;
  endfunction

  // bits 11:10 route a host word to this register or to register 0
  function automatic logic own_word(input logic [11:0] w);
    own_word = w[11:10] == `ACR1_SEL_VALUE;
  endfunction

  // plain modular difference, no clamping at either end of the range
  function automatic logic [9:0] less_offset(input logic [9:0] raw,
                                             input logic [9:0] off);
    less_offset = raw - off;
  endfunction

  // ----------------------------------------------------------------
  // field aliases
  // ----------------------------------------------------------------
  assign combined_style  = ctrl_reg[`ACR1_BIT_BUSSTYLE];
  assign straight_binary = ctrl_reg[`ACR1_BIT_FORMAT];

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  // both selects must agree; either one alone leaves the port idle
  assign sel_ok = !bus_in.select_low_active_n && bus_in.select_high_active;

  always_comb
  begin
    if (combined_style)
      wr_int = sel_ok && !bus_in.wr_n;
    else
      wr_int = sel_ok && !bus_in.wr_n && bus_in.rd_n;
  end

  // read pin is ignored in combined mode; direction high means read
  always_comb
  begin
    if (combined_style)
      rd_int = sel_ok && bus_in.wr_n;
    else
      rd_int = sel_ok && !bus_in.rd_n && bus_in.wr_n;
  end
  assign read_strobe_out = rd_int;

  // ----------------------------------------------------------------
  // strobe edge
  // ----------------------------------------------------------------
  // the host may hold a strobe for many clocks; latch on its leading edge only
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      wr_prev_reg <= 1'b0;
    else
      wr_prev_reg <= wr_int;
  end
  assign wr_take = wr_int && !wr_prev_reg;

  // ----------------------------------------------------------------
  // host word routing
  // ----------------------------------------------------------------
  assign own_take = wr_take && own_word(data_in);
  // register 0 lives elsewhere and only needs to see its own writes
  assign cr0_write_out = wr_take && !own_word(data_in);
  // a reset write never starts a calibration
  assign cal_start = own_take && data_in[`ACR1_BIT_OFFSET]
                     && !data_in[`ACR1_BIT_RESET];
  // a sample that ends calibration never reaches the result port
  assign cal_done = state_reg == acr1_pkg::ACR1_CAL && conv_valid_in;
  assign conv_shown = conv_valid_in && state_reg != acr1_pkg::ACR1_CAL;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (own_take)
    begin
      // a reset write reloads the reset value with the reset bit set, so a later resume starts clean
      if (data_in[`ACR1_BIT_RESET])
        ctrl_next = `ACR1_RESET_VALUE | 10'h001;
      else
        ctrl_next = data_in[9:0];
    end
  end

  // reset value keeps separate strobes, so the host can always reach us
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ctrl_reg <= `ACR1_RESET_VALUE;
    else
      ctrl_reg <= ctrl_next;
  end
  assign device_reset_out = ctrl_reg[`ACR1_BIT_RESET];
  assign ctrl_value_out   = ctrl_reg;

  // ----------------------------------------------------------------
  // sync generator clear
  // ----------------------------------------------------------------
  // one clock wide; the generator only needs an edge
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sync_gen_clear_out <= 1'b0;
    else
      sync_gen_clear_out <= own_take && data_in[`ACR1_BIT_SYNC];
  end

  // ----------------------------------------------------------------
  // calibration state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      acr1_pkg::ACR1_IDLE, acr1_pkg::ACR1_RUN:
        if (cal_start)
          state_next = acr1_pkg::ACR1_CAL;
      acr1_pkg::ACR1_CAL:
        if (conv_valid_in)
          state_next = acr1_pkg::ACR1_RUN;
      default:
        state_next = acr1_pkg::ACR1_IDLE;
    endcase
  end

  // device reset parks the machine; a pending measurement is dropped
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state_reg <= acr1_pkg::ACR1_IDLE;
    else if (device_reset_out)
      state_reg <= acr1_pkg::ACR1_IDLE;
    else
      state_reg <= state_next;
  end
  assign cal_zero_in_out = state_reg == acr1_pkg::ACR1_CAL;

  // ----------------------------------------------------------------
  // offset register
  // ----------------------------------------------------------------
  // forgotten in device reset, so a resumed device needs a new calibration
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      offset_reg <= 10'h000;
    else if (device_reset_out)
      offset_reg <= 10'h000;
    else if (cal_done)
      offset_reg <= conv_data_in;
  end

  // ----------------------------------------------------------------
  // result path
  // ----------------------------------------------------------------
  // calibration sample is swallowed, not shown as a result
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      result_valid_out <= 1'b0;
    else
      result_valid_out <= conv_shown && !device_reset_out;
  end

  // held between results so a slow reader still sees the last value
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      result_out <= 10'h000;
    else if (conv_shown)
      result_out <= fmt(less_offset(conv_data_in, offset_reg),
                        straight_binary);
  end
endmodule // acr1_ctrl

// [dv/acr1_ctrl_assertions.sv]
// checker for the second converter control register
`timescale 1ns/1ps
module acr1_ctrl_assertions (
  input wire logic core_clk_in, nrst_in, conv_valid_in, cal_zero_in_out, device_reset_out,
  input wire logic sync_gen_clear_out, read_strobe_out, result_valid_out, cr0_write_out,
  input wire acr1_pkg::acr1_bus_t bus_in,
  input wire logic [11:0] data_in,
  input wire logic [9:0] conv_data_in, result_out, ctrl_value_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic sel = !bus_in.select_low_active_n && bus_in.select_high_active;
  wire logic wr_int = sel && !bus_in.wr_n && (ctrl_value_out[6] || bus_in.rd_n);
  sequence s_take; !wr_int ##1 wr_int && data_in[11:10] == 2'h1 && !data_in[0]; endsequence
  a_write_lands:
    assert property (s_take |-> ##[1:2] ctrl_value_out == data_in[9:0]) else $error("lost");
  a_reset_state:
    assert property (device_reset_out |-> ctrl_value_out == 10'h031) else $error("rst");
  a_reset_quiet:
    assert property (device_reset_out && $past(device_reset_out) |-> !result_valid_out)
    else $error("quiet");
  a_sync_pulse:
    assert property (sync_gen_clear_out |-> ctrl_value_out[1] ##1 !sync_gen_clear_out)
    else $error("sync");
  a_read_decode:
    assert property (read_strobe_out == (sel && bus_in.wr_n && (ctrl_value_out[6] ||
    !bus_in.rd_n))) else $error("read");
  a_cal_store:
    assert property (cal_zero_in_out && conv_valid_in |=> !cal_zero_in_out && !result_valid_out)
    else $error("cal");
  a_result_due:
    assert property (conv_valid_in && !cal_zero_in_out && !device_reset_out |=> result_valid_out)
    else $error("res");
  a_cr0_route:
    assert property (cr0_write_out |-> sel && data_in[11:10] != 2'h1) else $error("cr0");
endmodule // acr1_ctrl_assertions

// [dv/acr1_host.sv]
// host processor model on the parallel port
`timescale 1ns/1ps
module acr1_host (
  input  wire logic           core_clk_in, // bus timing
  output acr1_pkg::acr1_bus_t bus_out,     // strobes, selects
  output logic [11:0]         data_out     // host word
);
  initial bus_out = 4'b1011;
  initial data_out = 12'h000;
  // one-cycle strobe then idle gap, so each word is taken once
  task automatic wr(input logic [11:0] w);
    @(posedge core_clk_in);
    bus_out <= 4'b0110; // direction low writes
    data_out <= {w[11:10], 1'b0, w[8:6], 4'hc, w[1:0]};
    @(posedge core_clk_in);
    bus_out <= 4'b1011;
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic rd();
    @(posedge core_clk_in);
    bus_out <= 4'b0111; // direction high reads
    @(posedge core_clk_in);
    bus_out <= 4'b1011;
  endtask
endmodule // acr1_host

// [dv/acr1_ctrl_bench.sv]
// self-checking bench for the second converter control register
`timescale 1ns/1ps
module acr1_ctrl_bench;
  logic core_clk_in = 1'b0, nrst_in = 1'b0, conv_valid_in = 1'b0, result_valid_out;
  logic [9:0] conv_data_in = 10'h000, result_out, ctrl_value_out;
  acr1_pkg::acr1_bus_t bus_in;
  logic [11:0] data_in;
  int bad_count = 0, checks = 0, cyc = 0, off = 0, fmt = 0, raw;
  bit quiet = 1'b0;
  always #25 core_clk_in = ~core_clk_in;
  acr1_host host_u (.core_clk_in(core_clk_in), .bus_out(bus_in), .data_out(data_in));
  acr1_ctrl dut_u (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .bus_in(bus_in),
    .data_in(data_in), .conv_valid_in(conv_valid_in), .conv_data_in(conv_data_in),
    .cal_zero_in_out(), .device_reset_out(), .sync_gen_clear_out(), .read_strobe_out(),
    .result_valid_out(result_valid_out), .result_out(result_out), .cr0_write_out(),
    .ctrl_value_out(ctrl_value_out));
  task automatic chk(input string n, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wchk(input logic [11:0] w, input logic [9:0] exp);
    host_u.wr(w);
    chk("ctrl", ctrl_value_out, exp);
  endtask
  task automatic conv(input bit cal);
    raw = $urandom_range(1023);
    @(posedge core_clk_in);
    conv_valid_in <= 1'b1;
    conv_data_in <= raw[9:0];
    @(posedge core_clk_in);
    conv_valid_in <= 1'b0;
    @(negedge core_clk_in);
    chk("valid", {9'h000, result_valid_out}, {9'h000, !cal && !quiet});
    if (cal) off = raw;
    else chk("res", result_out, 10'((raw - off) ^ (fmt << 9)));
  endtask
  task automatic finish_test();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, the run needs some 60 cycles
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      bad_count++;
      finish_test();
    end
  end
  initial
  begin
    raw = $urandom(6);
    repeat (6) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    chk("rst", ctrl_value_out, 10'h030);
    wchk(12'h432, 10'h032);
    conv(0);
    wchk(12'h530, 10'h130);
    conv(1);
    fmt = 1;
    wchk(12'h4b0, 10'h0b0);
    repeat (3) conv(0);
    $display("test format done");
    wchk(12'h031, 10'h0b0);
    wchk(12'h431, 10'h031);
    off = 0;
    fmt = 0;
    quiet = 1'b1;
    conv(0);
    quiet = 1'b0;
    wchk(12'h470, 10'h070);
    host_u.rd();
    wchk(12'h430, 10'h030);
    conv(0);
    $display("test reset done");
    finish_test();
  end
endmodule // acr1_ctrl_bench
bind acr1_ctrl acr1_ctrl_assertions chk_u (.*);
